// ### hw/bus_split_consts.svh
// Address map, widths and cycle counts of the bus splitter
`ifndef BUS_SPLIT_CONSTS_SVH
`define BUS_SPLIT_CONSTS_SVH

`define IRAM_BASE       24'h000000
`define IRAM_LAST       24'h000fff
`define PERIPH1_BASE    24'h004000
`define PERIPH1_LAST    24'h0043ff
`define PERIPH1_WIDE    24'h004200
`define PERIPH2_BASE    24'h005000
`define PERIPH2_LAST    24'h005fff
`define PERIPH2_WIDE_LO 24'h005300
`define PERIPH2_WIDE_HI 24'h00531f
`define FLASH_BASE      24'h008000
`define FLASH_LAST      24'h017fff
`define DISPLAY_BASE    24'h080000
`define DISPLAY_LAST    24'h08023f
`define COREIO_BASE     24'hfffc00

`define IRAM_CYCLES     3'h1
`define PERIPH1_CYCLES  3'h1
`define PERIPH2_CYCLES  3'h3
`define COREIO_CYCLES   3'h1
`define NONE_CYCLES     3'h1
`define FLASH_MIN       3'h1
`define FLASH_MAX       3'h5
`define DISPLAY_MIN     3'h2
`define DISPLAY_MAX     3'h5

`define UPPER_MSB       31
`define UPPER_LSB       24

`endif

// ### hw/bus_split_pkg.sv
// Types shared by the bus splitter modules
`default_nettype none
package bus_split_pkg;
  typedef enum logic [1:0] {size_8, size_16, size_32} size_t;
  typedef enum logic [1:0] {width_8, width_16, width_32} width_t;
  typedef enum logic [2:0]
  {
    area_none, area_iram, area_periph1, area_periph2, area_flash, area_display, area_coreio
  } area_t;
endpackage
`default_nettype wire

// ### hw/area_decoder.sv
// Address to area, device width and access cycle count
`include "bus_split_consts.svh"
`default_nettype none
module area_decoder
(
  input  wire logic [23:0]         addr,
  input  wire logic [2:0]          flash_cycles,
  input  wire logic [2:0]          display_cycles,
  output bus_split_pkg::area_t     area,
  output bus_split_pkg::width_t    width,
  output logic [2:0]               cycles
);
  import bus_split_pkg::*;

  always_comb
  begin
    area   = area_none;
    width  = width_32;
    cycles = `NONE_CYCLES;
    if (addr <= `IRAM_LAST)
    begin
      area   = area_iram;
      width  = width_32;
      cycles = `IRAM_CYCLES;
    end
    else if (addr >= `PERIPH1_BASE && addr <= `PERIPH1_LAST)
    begin
      area   = area_periph1;
      width  = (addr >= `PERIPH1_WIDE) ? width_16 : width_8;
      cycles = `PERIPH1_CYCLES;
    end
    else if (addr >= `PERIPH2_BASE && addr <= `PERIPH2_LAST)
    begin
      area   = area_periph2;
      width  = (addr >= `PERIPH2_WIDE_LO && addr <= `PERIPH2_WIDE_HI) ? width_16 : width_8;
      cycles = `PERIPH2_CYCLES;
    end
    else if (addr >= `FLASH_BASE && addr <= `FLASH_LAST)
    begin
      area   = area_flash;
      width  = width_16;
      cycles = (flash_cycles < `FLASH_MIN) ? `FLASH_MIN :
               (flash_cycles > `FLASH_MAX) ? `FLASH_MAX : flash_cycles;
    end
    else if (addr >= `DISPLAY_BASE && addr <= `DISPLAY_LAST)
    begin
      area   = area_display;
      width  = width_8;
      cycles = (display_cycles < `DISPLAY_MIN) ? `DISPLAY_MIN :
               (display_cycles > `DISPLAY_MAX) ? `DISPLAY_MAX : display_cycles;
    end
    else if (addr >= `COREIO_BASE)
    begin
      area   = area_coreio;
      width  = width_32;
      cycles = `COREIO_CYCLES;
    end
  end
endmodule
`default_nettype wire

// ### hw/access_counter.sv
// Down counter that holds one bus access for a loaded number of cycles
`default_nettype none
module access_counter
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       load,
  input  wire logic [2:0] load_value,
  output logic            busy,
  output logic            last
);
  typedef struct packed
  {
    logic       busy;
    logic [2:0] count;
  } cnt_state_t;

  cnt_state_t s;
  cnt_state_t next_s;

  always_comb
  begin
    next_s = s;
    if (s.busy)
    begin
      next_s.count = s.count - 3'h1;
      if (s.count == 3'h1)
      begin
        next_s.busy = 1'b0;
      end
    end
    if (load)
    begin
      next_s.busy  = 1'b1;
      next_s.count = load_value;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign last = s.busy && (s.count == 3'h1);
endmodule
`default_nettype wire

// ### hw/cpu_bus_access_splitter.sv
// CPU bus controller: area decode, access splitting and fetch serialisation
`include "bus_split_consts.svh"
`default_nettype none
// Overview of operation
// - One core clock period counts as exactly one bus cycle.
// - Split by width: 8-bit target 1/2/4, 16-bit 1/1/2, 32-bit always one.
// - Plain 32-bit writes send the top eight data bits as zero.
// - Plain 32-bit memory reads drop the top eight returned bits.
// - Interrupt stack accesses carry all 32 bits: status word high, return address low.
// - All other modules accept 8, 16 and 32-bit CPU accesses.
// - Fetch from flash never overlaps data access to flash, display or area 2.
// - Fetch from internal RAM and data to internal RAM run one after other.
// - A serialised fetch is lengthened by the data access cycles.
// - Internal RAM: 4K bytes at address zero, 32-bit wide, one cycle.
// - Flash: 64K bytes at vector base, 16-bit wide, 1 to 5 cycles.
// - Display RAM: 576 bytes, 8-bit wide, 2 to 5 cycles.
// - Peripheral area 1 at 0x4000, 1K bytes, one cycle per access.
// - Peripheral area 2, 4K bytes of 8-bit and 16-bit blocks, three cycles per access.
// - Top 1K bytes hold core I/O registers, one cycle.
module cpu_bus_access_splitter
(
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic [2:0]             flash_cycles,
  input  wire logic [2:0]             display_cycles,
  input  wire logic                   data_req,
  input  wire logic [23:0]            data_addr,
  input  wire bus_split_pkg::size_t   data_size,
  input  wire logic                   data_we,
  input  wire logic                   data_stack,
  input  wire logic [31:0]            data_wdata,
  output logic                        data_ack,
  output logic [31:0]                 data_rdata,
  input  wire logic                   fetch_req,
  input  wire logic [23:0]            fetch_addr,
  output logic                        fetch_ack,
  output logic [15:0]                 fetch_rdata,
  output logic                        dbus_req,
  output bus_split_pkg::area_t        dbus_area,
  output bus_split_pkg::width_t       dbus_width,
  output logic [23:0]                 dbus_addr,
  output logic                        dbus_we,
  output logic [31:0]                 dbus_wdata,
  input  wire logic [31:0]            dbus_rdata,
  output logic                        fbus_req,
  output bus_split_pkg::area_t        fbus_area,
  output logic [23:0]                 fbus_addr,
  input  wire logic [15:0]            fbus_rdata
);
  import bus_split_pkg::*;

  typedef enum logic {d_idle, d_access} dstate_t;
  typedef enum logic [1:0] {f_idle, f_wait, f_access} fstate_t;

  typedef struct packed
  {
    dstate_t     dstate;
    logic [23:0] dcur;
    size_t       dsize;
    logic        dwe;
    logic        dstack;
    logic [31:0] dshift;
    logic [31:0] dacc;
    logic [1:0]  piece;
    logic [1:0]  pieces;
    logic [1:0]  plog;
    area_t       darea;
    width_t      dwidth;
    logic [2:0]  dcycles;
    logic        dack;
    logic [31:0] drdata;
    fstate_t     fstate;
    logic [23:0] faddr;
    area_t       farea;
    logic [2:0]  fcycles;
    logic        fack;
    logic [15:0] frdata;
  } state_t;

  state_t      s;
  state_t      next_s;

  area_t       d_area;
  width_t      d_width;
  logic [2:0]  d_cycles;
  area_t       f_area;
  logic [2:0]  f_cycles;

  logic        dload;
  logic [2:0]  dload_val;
  logic        dcnt_busy;
  logic        dcnt_last;
  logic        fload;
  logic [2:0]  fload_val;
  logic        fcnt_busy;
  logic        fcnt_last;

  logic        data_accept;
  logic        data_last;
  logic [1:0]  acc_plog;
  logic [1:0]  bofs;
  logic [4:0]  boff;
  logic [31:0] lane_mask;
  logic [31:0] merged;

  // Overlap of a fetch area with a data area forces one after the other
  function automatic logic conflict(input area_t fa, input area_t da);
    conflict = ((fa == area_flash) &&
                (da == area_flash || da == area_display || da == area_periph2)) ||
               ((fa == area_iram) && (da == area_iram));
  endfunction

  function automatic logic is_memory(input area_t a);
    is_memory = (a == area_iram) || (a == area_flash) || (a == area_display);
  endfunction

  // Piece size is the smaller of access size and device width
  function automatic logic [1:0] piece_log(input size_t sz, input width_t w);
    piece_log = (w < sz) ? 2'(w) : 2'(sz);
  endfunction

  area_decoder data_decoder
  (
    .addr           (data_addr),
    .flash_cycles   (flash_cycles),
    .display_cycles (display_cycles),
    .area           (d_area),
    .width          (d_width),
    .cycles         (d_cycles)
  );

  area_decoder fetch_decoder
  (
    .addr           (fetch_addr),
    .flash_cycles   (flash_cycles),
    .display_cycles (display_cycles),
    .area           (f_area),
    .width          (),
    .cycles         (f_cycles)
  );

  access_counter data_counter
  (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .load       (dload),
    .load_value (dload_val),
    .busy       (dcnt_busy),
    .last       (dcnt_last)
  );

  access_counter fetch_counter
  (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .load       (fload),
    .load_value (fload_val),
    .busy       (fcnt_busy),
    .last       (fcnt_last)
  );

  always_comb
  begin
    next_s    = s;
    dload     = 1'b0;
    dload_val = s.dcycles;
    fload     = 1'b0;
    fload_val = s.fcycles;
    next_s.dack = 1'b0;
    next_s.fack = 1'b0;

    // A pending or running conflicting fetch holds new data off
    data_accept = (s.dstate == d_idle) && data_req &&
                  !((s.fstate != f_idle) && conflict(s.farea, d_area));
    data_last   = (s.dstate == d_access) && dcnt_last && (s.piece == s.pieces);
    acc_plog    = piece_log(data_size, d_width);

    bofs = 2'(s.piece << s.plog);
    boff = {bofs, 3'b000};
    unique case (s.plog)
      2'h0:    lane_mask = 32'h000000ff;
      2'h1:    lane_mask = 32'h0000ffff;
      default: lane_mask = 32'hffffffff;
    endcase
    merged = s.dacc | ((dbus_rdata & lane_mask) << boff);

    unique case (s.dstate)
      d_idle:
      begin
        if (data_accept)
        begin
          next_s.dstate  = d_access;
          next_s.dcur    = data_addr;
          next_s.dsize   = data_size;
          next_s.dwe     = data_we;
          next_s.dstack  = data_stack;
          next_s.darea   = d_area;
          next_s.dwidth  = d_width;
          next_s.dcycles = d_cycles;
          next_s.plog    = acc_plog;
          next_s.piece   = 2'h0;
          next_s.dacc    = 32'h00000000;
          unique case (2'(data_size - acc_plog))
            2'h0:    next_s.pieces = 2'h0;
            2'h1:    next_s.pieces = 2'h1;
            default: next_s.pieces = 2'h3;
          endcase
          if (data_size == size_32 && !data_stack)
          begin
            next_s.dshift = {8'h00, data_wdata[`UPPER_LSB-1:0]};
          end
          else
          begin
            next_s.dshift = data_wdata;
          end
          dload     = 1'b1;
          dload_val = d_cycles;
        end
      end
      d_access:
      begin
        if (dcnt_last)
        begin
          next_s.dacc = merged;
          if (s.piece == s.pieces)
          begin
            next_s.dstate = d_idle;
            next_s.dack   = 1'b1;
            next_s.drdata = merged;
            if (s.dsize == size_32 && !s.dstack && is_memory(s.darea))
            begin
              next_s.drdata[`UPPER_MSB:`UPPER_LSB] = 8'h00;
            end
          end
          else
          begin
            next_s.piece  = s.piece + 2'h1;
            next_s.dcur   = s.dcur + 24'(3'b001 << s.plog);
            next_s.dshift = s.dshift >> (6'(8) << s.plog);
            dload         = 1'b1;
          end
        end
      end
    endcase

    unique case (s.fstate)
      f_idle:
      begin
        if (fetch_req)
        begin
          next_s.faddr   = fetch_addr;
          next_s.farea   = f_area;
          next_s.fcycles = f_cycles;
          if (((s.dstate == d_access) && conflict(f_area, s.darea)) ||
              (data_accept && conflict(f_area, d_area)))
          begin
            next_s.fstate = f_wait;
          end
          else
          begin
            next_s.fstate = f_access;
            fload         = 1'b1;
            fload_val     = f_cycles;
          end
        end
      end
      f_wait:
      begin
        if (data_last || s.dstate == d_idle)
        begin
          next_s.fstate = f_access;
          fload         = 1'b1;
        end
      end
      f_access:
      begin
        if (fcnt_last)
        begin
          next_s.fstate = f_idle;
          next_s.fack   = 1'b1;
          next_s.frdata = fbus_rdata;
        end
      end
      default:
      begin
        next_s.fstate = f_idle;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign data_ack    = s.dack;
  assign data_rdata  = s.drdata;
  assign fetch_ack   = s.fack;
  assign fetch_rdata = s.frdata;
  assign dbus_req    = dcnt_busy;
  assign dbus_area   = s.darea;
  assign dbus_width  = s.dwidth;
  assign dbus_addr   = s.dcur;
  assign dbus_we     = s.dwe;
  assign dbus_wdata  = s.dshift;
  assign fbus_req    = fcnt_busy;
  assign fbus_area   = s.farea;
  assign fbus_addr   = s.faddr;
endmodule
`default_nettype wire

// ### bench/bus_target_model.sv
// Memory and register responder behind the splitter's data and fetch buses
`default_nettype none
module bus_target_model
(
  input  wire logic [23:0] dbus_addr,
  input  wire logic        dbus_req,
  input  wire logic [23:0] fbus_addr,
  input  wire logic        fbus_req,
  output logic      [31:0] dbus_rdata,
  output logic      [15:0] fbus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic [7:0] pb(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction
  // Byte lanes from the piece address upward; idle buses show inverted data
  always_comb
  begin
    dbus_rdata = {pb(dbus_addr + 24'h3), pb(dbus_addr + 24'h2),
                  pb(dbus_addr + 24'h1), pb(dbus_addr)};
    fbus_rdata = {pb(fbus_addr + 24'h1), pb(fbus_addr)};
    if (!dbus_req)
      dbus_rdata = ~dbus_rdata;
    if (!fbus_req)
      fbus_rdata = ~fbus_rdata;
  end
endmodule
`default_nettype wire

// ### bench/splitter_chk.sv
// Port-level assertions for the CPU bus access splitter
`default_nettype none
module splitter_chk
  import bus_split_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  input wire logic                  data_req,
  input wire bus_split_pkg::size_t  data_size,
  input wire logic                  data_we,
  input wire logic                  data_stack,
  input wire logic [31:0]           data_wdata,
  input wire logic                  data_ack,
  input wire logic                  dbus_req,
  input wire bus_split_pkg::area_t  dbus_area,
  input wire bus_split_pkg::width_t dbus_width,
  input wire logic [23:0]           dbus_addr,
  input wire logic                  dbus_we,
  input wire logic [31:0]           dbus_wdata,
  input wire logic                  fbus_req,
  input wire bus_split_pkg::area_t  fbus_area
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_iram_decode:
    assert property (dbus_req && dbus_addr <= 24'h000fff |->
      dbus_area == area_iram && dbus_width == width_32) else $error("iram decode");
  chk_flash_decode:
    assert property (dbus_req && dbus_addr inside {[24'h008000:24'h017fff]} |->
      dbus_area == area_flash && dbus_width == width_16) else $error("flash decode");
  chk_display_decode:
    assert property (dbus_req && dbus_addr inside {[24'h080000:24'h08023f]} |->
      dbus_area == area_display && dbus_width == width_8) else $error("display decode");
  chk_block_width:
    assert property (dbus_req && dbus_addr inside {[24'h004200:24'h0043ff],
      [24'h005300:24'h00531f]} |-> dbus_width == width_16) else $error("block width");
  chk_area2_cycles:
    assert property ($rose(dbus_req) && dbus_area == area_periph2 |=>
      (dbus_req && $stable(dbus_addr))[*2] ##1 (!dbus_req || !$stable(dbus_addr)))
      else $error("area 2 piece length");
  chk_fast_cycles:
    assert property ($rose(dbus_req) && dbus_area inside {area_iram, area_periph1,
      area_coreio} |=> !dbus_req || dbus_addr != $past(dbus_addr))
      else $error("one cycle piece length");
  chk_fetch_single:
    assert property ($rose(fbus_req) && fbus_area == area_iram |=> !fbus_req)
      else $error("ram fetch length");
  chk_flash_overlap:
    assert property (fbus_req && fbus_area == area_flash |->
      !(dbus_req && dbus_area inside {area_flash, area_display, area_periph2}))
      else $error("flash fetch overlaps data");
  chk_iram_overlap:
    assert property (fbus_req && fbus_area == area_iram |->
      !(dbus_req && dbus_area == area_iram)) else $error("ram fetch overlaps data");
  chk_upper_zero:
    assert property (data_req && data_we && data_size == size_32 && !data_stack &&
      dbus_req && dbus_width == width_32 |-> dbus_wdata[31:24] == 8'h00)
      else $error("upper write byte not zero");
  chk_piece_order:
    assert property (dbus_req && $past(dbus_req) && dbus_addr != $past(dbus_addr) |->
      dbus_addr == $past(dbus_addr) + (dbus_width == width_8 ? 24'h1 : 24'h2))
      else $error("piece address order");
  chk_ack_pulse:
    assert property (data_ack |=> !data_ack) else $error("data ack too long");
  chk_stack_whole:
    assert property (data_req && data_we && data_stack && data_size == size_32 &&
      dbus_req && dbus_width == width_32 |-> dbus_wdata == data_wdata)
      else $error("stack write not whole");
  chk_write_flag:
    assert property (data_req && dbus_req |-> dbus_we == data_we)
      else $error("write flag differs");
endmodule
bind cpu_bus_access_splitter splitter_chk i_splitter_chk (.*);
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the bus splitter against a behavioural access model
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bus_split_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  flash_cycles = 3'h1;
  logic [2:0]  display_cycles = 3'h2;
  logic        data_req = 1'b0;
  logic [23:0] data_addr = 24'h000000;
  size_t       data_size = size_8;
  logic        data_we = 1'b0;
  logic        data_stack = 1'b0;
  logic [31:0] data_wdata = 32'h00000000;
  logic        fetch_req = 1'b0;
  logic [23:0] fetch_addr = 24'h000000;
  logic        data_ack, fetch_ack, dbus_req, dbus_we, fbus_req;
  logic [31:0] data_rdata, dbus_wdata, dbus_rdata;
  logic [23:0] dbus_addr, fbus_addr;
  logic [15:0] fetch_rdata, fbus_rdata;
  area_t       dbus_area, fbus_area;
  width_t      dbus_width;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          fc, dc;
  logic [23:0] base [8] = '{24'h000100, 24'h004100, 24'h004200, 24'h005000,
                            24'h005300, 24'h008000, 24'h080000, 24'hfffc00};
  int          wb [8] = '{4, 1, 2, 1, 2, 2, 1, 4};
  int          cy [8] = '{1, 1, 1, 3, 3, 0, 0, 1};
  int          fi [6] = '{5, 5, 5, 5, 0, 0};
  int          di [6] = '{5, 6, 3, 0, 0, 5};
  int          cf [6] = '{1, 1, 1, 0, 1, 0};

  cpu_bus_access_splitter i_cpu_bus_access_splitter (.*);
  bus_target_model i_bus_target_model (.*);

  always #20 sys_clk = ~sys_clk;

  function automatic int cyc(input int i);
    return i == 5 ? fc : i == 6 ? dc : cy[i];
  endfunction
  function automatic int total(input int i, input int sz);
    return ((1 << sz) > wb[i] ? (1 << sz) / wb[i] : 1) * cyc(i);
  endfunction
  function automatic logic [7:0] pb(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction

  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic pick;
    fc = 1 + $urandom % 5;
    dc = 2 + $urandom % 4;
    flash_cycles = 3'(fc);
    display_cycles = 3'(dc);
  endtask
  task automatic acc(input logic [23:0] a, input int sz, input logic w, input logic s,
                     input int tot, input bit z, input bit f, input logic [23:0] fa,
                     input int flat);
    int dn;
    int fn;
    logic [31:0] e;
    logic [31:0] m;
    dn = 0;
    fn = 0;
    for (int k = 0; k < 4; k++)
      e[8*k +: 8] = pb(a + 24'(k));
    m = sz == 2 ? 32'hffffffff : sz == 1 ? 32'h0000ffff : 32'h000000ff;
    if (z)
      e[31:24] = 8'h00;
    data_addr = a;
    data_size = size_t'(sz);
    data_we = w;
    data_stack = s;
    data_wdata = $urandom;
    fetch_addr = fa;
    fetch_req = f;
    data_req = 1'b1;
    for (int n = 1; n < 80 && (data_req || fetch_req); n++)
    begin
      @(negedge sys_clk);
      if (data_req && data_ack === 1'b1)
      begin
        dn = n;
        data_req = 1'b0;
      end
      if (fetch_req && fetch_ack === 1'b1)
      begin
        fn = n;
        fetch_req = 1'b0;
      end
    end
    chk("data latency", tot + 1, dn);
    if (!w)
      chk("read data", e & m, data_rdata & m);
    if (f)
      chk("fetch latency", flat + 1, fn);
    if (f)
      chk("fetch data", {pb(fa + 24'h1), pb(fa)}, {16'h0, fetch_rdata});
    @(negedge sys_clk);
  endtask

  initial
  begin
    void'($urandom(32'hd1b2));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    chk("ack after reset", 32'h0, {31'h0, data_ack});
    for (int i = 0; i < 8; i++)
      for (int t = 0; t < 6; t++)
      begin
        pick();
        if (i != 5 || t[0] == 1'b0 || t == 3)
          acc(base[i] + 24'($urandom % 4 * 4), t / 2, t[0], 1'b0, total(i, t / 2),
              t >= 4 && (i == 0 || i == 5 || i == 6), 1'b0, 24'h0, 0);
      end
    acc(24'h000040, 2, 1'b1, 1'b1, 1, 1'b0, 1'b0, 24'h0, 0);
    acc(24'h000040, 2, 1'b0, 1'b1, 1, 1'b0, 1'b0, 24'h0, 0);
    $display("test split done");
    for (int j = 0; j < 6; j++)
    begin
      pick();
      acc(base[di[j]], 1, 1'b0, 1'b0, total(di[j], 1), 1'b0, 1'b1, base[fi[j]] + 24'h80,
          cyc(fi[j]) + cf[j] * total(di[j], 1));
    end
    $display("test fetch done");
    stop_test();
  end

  initial
  begin
    #400000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
